// ### logic/alarm_regs.svh
`ifndef ALARM_REGS_SVH
`define ALARM_REGS_SVH
// ==================================================
// register offsets (byte addresses)
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_ERRIN       8'h08
`define REG_TEMP        8'h0c
`define REG_CYCLES      8'h10
`define REG_OPTIME      8'h14
`define REG_CAL_WR      8'h18
`define REG_CAL_RD      8'h1c
`define REG_LOG_CNT     8'h20
`define REG_LOG_IDX     8'h24
`define REG_LOG_DATA    8'h28
`define REG_LOG_STAMP   8'h2c
`define REG_PROTO_WORD  8'h30
// ==================================================
// ctrl field positions
`define CTRL_SCALE_500  0
`define CTRL_RELAY_INV  1
`define CTRL_START      2
`define CTRL_RST_REQ    3
`define CTRL_COMPACT    4
`define CTRL_RESET      32'h0000_0000
// ==================================================
// timing
`define CLK_HZ          10000000
`define TICK_HZ         8
`define TICK_CYC        (`CLK_HZ / `TICK_HZ)
`define OPTIME_STEP_S   360
`define LOG_DEPTH       400
// ==================================================
// dac scale: 10 V full scale, 12-bit code
`define DAC_FULL        12'hfff
`define DAC_STEP        12'h110
`endif

// ### logic/alarm_pkg.sv
package alarm_pkg;
   typedef enum logic [1:0] {
      CLS_NONE   = 2'b00,
      CLS_FAST   = 2'b01,
      CLS_SLOW   = 2'b10,
      CLS_STEADY = 2'b11
   } alarm_class_t;
   typedef struct packed {
      logic [9:0]   err_no;
      logic [3:0]   level;
      alarm_class_t cls;
   } err_info_t;
   typedef struct packed {
      logic [9:0]  err_no;
      logic        cal_event;
      logic        stamp_valid;
      logic [31:0] stamp;
   } log_entry_t;
endpackage

// ### logic/err_classifier.sv
`timescale 1ns/1ps
`include "alarm_regs.svh"
module err_classifier
   import alarm_pkg::*;
(
   input  wire logic [9:0] err_no,
   output err_info_t       info
);
   always_comb begin
      info.err_no = err_no;
      info.cls    = CLS_NONE;
      info.level  = 4'h0;
      if (err_no == 10'd8 || err_no == 10'd9 || err_no == 10'd211 ||
          (err_no >= 10'd104 && err_no <= 10'd106) ||
          err_no == 10'd302 || err_no == 10'd303) begin
         info.cls = CLS_FAST;
      end else if ((err_no >= 10'd10 && err_no <= 10'd12) ||
                   (err_no >= 10'd111 && err_no <= 10'd114)) begin
         info.cls = CLS_SLOW;
      end else if (err_no != 10'd0) begin
         info.cls = CLS_STEADY;
      end
      if (err_no >= 10'd1 && err_no <= 10'd12) begin
         info.level = err_no[3:0];
      end else if (err_no >= 10'd101 && err_no <= 10'd103) begin
         info.level = 4'(err_no - 10'd100);
      end else if (err_no >= 10'd104 && err_no <= 10'd106) begin
         info.level = 4'h8;
      end else if (err_no == 10'd107 || err_no == 10'd108 ||
                   err_no == 10'd307 || err_no == 10'd308) begin
         info.level = 4'h4;
      end else if (err_no >= 10'd111 && err_no <= 10'd114) begin
         info.level = 4'ha;
      end else if (err_no >= 10'd201 && err_no <= 10'd203) begin
         info.level = 4'h5;
      end else if (err_no >= 10'd900) begin
         info.level = 4'h7;
      end else if (err_no != 10'd0) begin
         info.level = 4'hd;
      end
   end
endmodule

// ### logic/alarm_signalling_unit.sv
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "alarm_regs.svh"
module alarm_signalling_unit
   import alarm_pkg::*;
#(
   parameter int TICK_CYCLES = `TICK_CYC,
   parameter int LOG_DEPTH   = `LOG_DEPTH
)(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        web_rd,
   output logic [31:0]      web_cal_data,
   output logic             alarm_lamp,
   output logic             alarm_relay,
   output logic             alarm_flag,
   output logic [11:0]      dac_code
);
   // ==================================================
   // state
   logic [31:0] ctrl_ff;
   logic [9:0]  err_ff;
   logic [9:0]  err_prev_ff;
   logic [9:0]  temp_ff;
   logic        latched_ff;
   logic [9:0]  latched_err_ff;
   logic        started_ff;
   logic        rst_req_d_ff;
   logic        start_d_ff;
   logic [31:0] cycles_ff;
   logic [31:0] optime_ff;
   logic [31:0] cal_ff;
   logic        cal_valid_ff;
   logic [31:0] sec_cnt_ff;
   logic [8:0]  step_cnt_ff;
   logic [31:0] tick_cnt_ff;
   logic [2:0]  phase_ff;
   logic [8:0]  wr_ptr_ff;
   logic [8:0]  log_cnt_ff;
   logic [8:0]  log_idx_ff;
   log_entry_t  log_mem [LOG_DEPTH];
   logic        aw_ok_ff;
   logic        w_ok_ff;
   logic [7:0]  awaddr_ff;
   logic [31:0] wdata_ff;
   err_info_t   info;
   logic        tick;
   logic        new_err;
   logic        do_write;
   logic        cal_event;

   err_classifier u_cls (
      .err_no (latched_err_ff),
      .info   (info)
   );

   // ==================================================
   // common tick
   assign tick = (tick_cnt_ff == 32'(TICK_CYCLES - 1));
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt_ff <= 32'h0;
         phase_ff    <= 3'h0;
      end else if (tick) begin
         tick_cnt_ff <= 32'h0;
         phase_ff    <= phase_ff + 3'h1;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 32'h1;
      end
   end

   // ==================================================
   // alarm latch
   assign new_err   = (err_ff != 10'h0) && (err_ff != err_prev_ff);
   assign cal_event = ctrl_ff[`CTRL_START] & ~start_d_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         latched_ff     <= 1'b0;
         latched_err_ff <= 10'h0;
         started_ff     <= 1'b0;
         rst_req_d_ff   <= 1'b0;
         start_d_ff     <= 1'b0;
         err_prev_ff    <= 10'h0;
      end else begin
         rst_req_d_ff <= ctrl_ff[`CTRL_RST_REQ];
         start_d_ff   <= ctrl_ff[`CTRL_START];
         err_prev_ff  <= err_ff;
         // clear on falling reset bit; new error wins
         if (new_err) begin
            latched_ff     <= 1'b1;
            latched_err_ff <= err_ff;
            started_ff     <= 1'b0;
         end else if (rst_req_d_ff && !ctrl_ff[`CTRL_RST_REQ]) begin
            latched_ff     <= 1'b0;
            latched_err_ff <= 10'h0;
            started_ff     <= 1'b0;
         end else if (latched_ff && ctrl_ff[`CTRL_START]) begin
            started_ff <= 1'b1;
         end
      end
   end

   // ==================================================
   // lamp, relay, analogue output
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         alarm_lamp  <= 1'b0;
         alarm_relay <= 1'b0;
         alarm_flag  <= 1'b0;
         dac_code    <= 12'h0;
      end else begin
         alarm_flag <= latched_ff;
         alarm_relay <= ctrl_ff[`CTRL_RELAY_INV] ^
            (latched_ff && (info.cls == CLS_STEADY || started_ff));
         case (info.cls)
            CLS_FAST:   alarm_lamp <= started_ff | phase_ff[0];
            CLS_SLOW:   alarm_lamp <= started_ff | phase_ff[2];
            CLS_STEADY: alarm_lamp <= 1'b1;
            default:    alarm_lamp <= 1'b0;
         endcase
         if (!latched_ff) begin
            dac_code <= ctrl_ff[`CTRL_SCALE_500] ?
               12'((temp_ff >= 10'd500) ? 32'hfff :
                   (32'(temp_ff) * 32'hfff) / 32'd500) :
               12'((temp_ff >= 10'd300) ? 32'hfff :
                   (32'(temp_ff) * 32'hfff) / 32'd300);
         // toggle to end value until start
         end else if (info.cls != CLS_STEADY && !started_ff &&
                      phase_ff[2]) begin
            dac_code <= `DAC_FULL;
         end else begin
            dac_code <= 12'(info.level * `DAC_STEP);
         end
      end
   end

   // ==================================================
   // counters and calendar
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cycles_ff   <= 32'h0;
         optime_ff   <= 32'h0;
         sec_cnt_ff  <= 32'h0;
         step_cnt_ff <= 9'h0;
         cal_ff      <= 32'h0;
         cal_valid_ff <= 1'b0;
      end else begin
         if (cal_event) begin
            cycles_ff <= cycles_ff + 32'h1;
         end
         if (sec_cnt_ff == 32'(`CLK_HZ - 1)) begin
            sec_cnt_ff <= 32'h0;
            cal_ff     <= cal_ff + 32'h1;
            if (step_cnt_ff == 9'(`OPTIME_STEP_S - 1)) begin
               step_cnt_ff <= 9'h0;
               optime_ff   <= optime_ff + 32'h1;
            end else begin
               step_cnt_ff <= step_cnt_ff + 9'h1;
            end
         end else begin
            sec_cnt_ff <= sec_cnt_ff + 32'h1;
         end
         if (do_write && awaddr_ff == `REG_CAL_WR) begin
            cal_ff       <= wdata_ff;
            cal_valid_ff <= 1'b1;
         end
      end
   end

   // ==================================================
   // event log
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr_ff  <= 9'h0;
         log_cnt_ff <= 9'h0;
      end else if (new_err) begin
         wr_ptr_ff <= (wr_ptr_ff == 9'(LOG_DEPTH - 1)) ? 9'h0 :
                      wr_ptr_ff + 9'h1;
         if (log_cnt_ff != 9'(LOG_DEPTH)) begin
            log_cnt_ff <= log_cnt_ff + 9'h1;
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (new_err) begin
         log_mem[wr_ptr_ff] <= '{err_no: err_ff,
            cal_event: (err_ff == 10'd8 || err_ff == 10'd9),
            stamp_valid: cal_valid_ff, stamp: cal_ff};
      end
   end

   // ==================================================
   // web read port
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         web_cal_data <= 32'h0;
      end else if (web_rd) begin
         web_cal_data <= cal_valid_ff ? cal_ff : 32'hffff_ffff;
      end
   end

   // ==================================================
   // axi4-lite write
   assign do_write = aw_ok_ff && w_ok_ff && !s_axi_bvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_ok_ff      <= 1'b0;
         w_ok_ff       <= 1'b0;
         awaddr_ff     <= 8'h0;
         wdata_ff      <= 32'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
      end else begin
         s_axi_awready <= !aw_ok_ff && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_ok_ff && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ok_ff  <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ok_ff  <= 1'b1;
            wdata_ff <= s_axi_wdata;
         end
         if (do_write) begin
            aw_ok_ff     <= 1'b0;
            w_ok_ff      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_ff == `REG_CTRL ||
                             awaddr_ff == `REG_ERRIN ||
                             awaddr_ff == `REG_TEMP ||
                             awaddr_ff == `REG_CAL_WR ||
                             awaddr_ff == `REG_LOG_IDX) ? 2'b00 : 2'b10;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   // full-word writes only; strobes ignored for simplicity
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_ff    <= `CTRL_RESET;
         err_ff     <= 10'h0;
         temp_ff    <= 10'h0;
         log_idx_ff <= 9'h0;
      end else if (do_write) begin
         case (awaddr_ff)
            `REG_CTRL:    ctrl_ff    <= wdata_ff;
            `REG_ERRIN:   err_ff     <= wdata_ff[9:0];
            `REG_TEMP:    temp_ff    <= wdata_ff[9:0];
            `REG_LOG_IDX: log_idx_ff <= wdata_ff[8:0];
            default:      ;
         endcase
      end
   end

   // ==================================================
   // axi4-lite read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= 2'b00;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            case (s_axi_araddr)
               `REG_CTRL:   s_axi_rdata <= ctrl_ff;
               `REG_STATUS: s_axi_rdata <= {20'h0, info.level,
                  info.cls, 5'h0, latched_ff};
               `REG_ERRIN:  s_axi_rdata <= {22'h0, latched_err_ff};
               `REG_TEMP:   s_axi_rdata <= {22'h0, temp_ff};
               `REG_CYCLES: s_axi_rdata <= cycles_ff;
               `REG_OPTIME: s_axi_rdata <= optime_ff;
               `REG_CAL_RD: s_axi_rdata <= cal_ff;
               `REG_LOG_CNT: s_axi_rdata <= {22'h0, cal_valid_ff,
                  log_cnt_ff};
               `REG_LOG_IDX: s_axi_rdata <= {23'h0, log_idx_ff};
               `REG_LOG_DATA: s_axi_rdata <= {20'h0,
                  log_mem[log_idx_ff].stamp_valid,
                  log_mem[log_idx_ff].cal_event,
                  log_mem[log_idx_ff].err_no};
               `REG_LOG_STAMP: s_axi_rdata <= log_mem[log_idx_ff].stamp;
               `REG_PROTO_WORD: s_axi_rdata <= ctrl_ff[`CTRL_COMPACT] ?
                  {16'h0, latched_ff, 11'h0, latched_err_ff[3:0]} :
                  {16'h0, latched_ff, 3'h0, latched_err_ff[3:0], 8'h0};
               default: begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= 2'b10;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

// ### dv/alarm_signalling_unit_asserts.sv
`timescale 1ns/1ps
module alarm_signalling_unit_chk (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_wvalid,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        alarm_lamp,
   input wire logic        alarm_relay,
   input wire logic        alarm_flag,
   input wire logic [11:0] dac_code
);
   default clocking cb @(posedge aclk); endclocking
   // =====
   // alarm outputs
   a_reset_quiet: assert property (
      !aresetn |=> !alarm_flag && !alarm_lamp && !alarm_relay && dac_code == 0)
      else $error("outputs not clear after reset");
   a_lamp_idle: assert property (
      disable iff (!aresetn) (!alarm_flag)[*3] |-> !alarm_lamp)
      else $error("lamp lit without alarm");
   // start may end a blink phase early, so only unstarted blinks are timed
   a_blink_gap: assert property (
      disable iff (!aresetn)
      alarm_flag[*6] ##0 ($changed(alarm_lamp) && !alarm_relay) |=>
      ($stable(alarm_lamp) || alarm_relay || !alarm_flag)[*3])
      else $error("lamp toggles faster than the tick");
   a_dac_alarm: assert property (
      disable iff (!aresetn) alarm_flag[*4] |-> dac_code != 12'h000)
      else $error("no error level during alarm");
   // =====
   // register bus
   a_bresp_ok: assert property (
      disable iff (!aresetn)
      s_axi_bvalid |-> s_axi_bresp inside {2'b00, 2'b10})
      else $error("illegal write response");
   a_bvalid_hold: assert property (
      disable iff (!aresetn)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rvalid_hold: assert property (
      disable iff (!aresetn)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_wr_answer: assert property (
      disable iff (!aresetn)
      s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |-> ##[1:4] s_axi_bvalid)
      else $error("write not answered");
   a_rd_answer: assert property (
      disable iff (!aresetn)
      s_axi_arvalid && !s_axi_rvalid |-> ##[1:3] s_axi_rvalid)
      else $error("read not answered");
   cover property (alarm_flag && alarm_relay);
   cover property (alarm_flag && !alarm_relay && alarm_lamp);
   cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule
bind alarm_signalling_unit alarm_signalling_unit_chk chk (.*);

// ### dv/machine_ctl.sv
`timescale 1ns/1ps
module machine_ctl (
   input  wire logic        aclk,
   output logic [7:0]       s_axi_awaddr,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   output logic [7:0]       s_axi_araddr,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready,
   output logic             hung
);
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid} = '0;
      {s_axi_rready, hung} = '0;
   end
   // =====
   // released payloads are inverted so stale values never look valid
   task automatic wr(input logic [7:0] a, input logic [31:0] v,
                     output logic [1:0] r);
      int n;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_wstrb   <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge aclk);
         if (s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr  <= ~a;
         end
         if (s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata  <= ~v;
         end
         if (s_axi_bvalid) break;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n == 64) hung <= 1'b1;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] r);
      int n;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge aclk);
         if (s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr  <= ~a;
         end
         if (s_axi_rvalid) break;
      end
      v = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n == 64) hung <= 1'b1;
      @(posedge aclk);
   endtask
   task automatic clear_alarm(input logic [31:0] base);
      logic [1:0] r;
      wr(8'h00, base | 32'h8, r);
      wr(8'h00, base, r);
   endtask
endmodule

// ### dv/alarm_signalling_unit_bench.sv
`timescale 1ns/1ps
`include "alarm_regs.svh"
module alarm_signalling_unit_bench;
   import alarm_pkg::*;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        web_rd = 1'b0;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, hung;
   logic        alarm_lamp, alarm_relay, alarm_flag;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [3:0]  s_axi_wstrb;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [11:0] dac_code;
   logic [31:0] s_axi_wdata, s_axi_rdata, web_cal_data, d, c0;
   int          fails = 0;
   int          tests_run = 0;
   int          lt, fc, dc;
   int          fast [8] = '{8, 9, 104, 105, 106, 211, 302, 303};
   int          slow [7] = '{10, 11, 12, 111, 112, 113, 114};
   int          hard [20] = '{1, 2, 3, 4, 5, 6, 7, 101, 102, 103, 107, 108,
                              201, 202, 203, 307, 308, 901, 950, 999};
   int          blink [2] = '{8, 10};
   int          tog [2] = '{16, 4};
   always #50 aclk = ~aclk;
   alarm_signalling_unit #(.TICK_CYCLES(4)) uut (.*);
   machine_ctl ctl (.*);
   // =====
   // helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: seen %h, expected %h",
                  $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   always @(posedge hung) begin
      fails++;
      close_out();
   end
   task automatic idle(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic raise(input int e);
      ctl.wr(`REG_ERRIN, 32'(e), r);
      idle(2);
   endtask
   task automatic drop();
      ctl.wr(`REG_ERRIN, 32'h0, r);
      ctl.clear_alarm(32'h0);
      idle(3);
   endtask
   task automatic classify(input int e, input alarm_class_t c);
      raise(e);
      ctl.rd(`REG_STATUS, d, r);
      check(32'(d[7:6]), 32'(c));
      drop();
   endtask
   // whole periods only, so the tick phase cannot change the counts
   task automatic watch(input int n);
      logic        l;
      logic [11:0] v;
      lt = 0;
      fc = 0;
      dc = 0;
      @(negedge aclk);
      l = alarm_lamp;
      v = dac_code;
      repeat (n) begin
         @(negedge aclk);
         if (alarm_lamp !== l) lt++;
         if (dac_code !== v) dc++;
         if (dac_code === `DAC_FULL) fc++;
         l = alarm_lamp;
         v = dac_code;
      end
      @(posedge aclk);
   endtask
   // =====
   // sequence
   initial begin
      idle(2);
      aresetn <= 1'b1;
      idle(1);
      check(32'({alarm_flag, alarm_lamp, alarm_relay, dac_code}), 32'h0);
      ctl.rd(`REG_LOG_CNT, d, r);
      check(32'(d[9:0]), 32'h0);
      web_rd <= 1'b1;
      idle(2);
      check(web_cal_data, 32'hffff_ffff);
      ctl.wr(`REG_TEMP, 32'd300, r);
      idle(2);
      check(32'(dac_code), 32'(`DAC_FULL));
      ctl.wr(`REG_CTRL, 32'h1, r);
      idle(2);
      check(32'(dac_code), 32'h999);
      ctl.wr(`REG_CTRL, 32'h0, r);
      ctl.wr(`REG_TEMP, 32'd0, r);
      ctl.rd(8'hfc, d, r);
      check(d, 32'h0);
      check(32'(r), 32'h2);
      ctl.rd(`REG_CYCLES, c0, r);
      ctl.wr(`REG_CYCLES, 32'h0, r);
      check(32'(r), 32'h2);
      ctl.wr(`REG_OPTIME, 32'h5, r);
      check(32'(r), 32'h2);
      ctl.rd(`REG_OPTIME, d, r);
      check(d, 32'h0);
      ctl.wr(`REG_CTRL, 32'h4, r);
      ctl.wr(`REG_CTRL, 32'h0, r);
      ctl.rd(`REG_CYCLES, d, r);
      check(d, c0 + 32'h1);
      ctl.rd(`REG_LOG_CNT, c0, r);
      raise(1);
      check(32'({alarm_flag, alarm_lamp, alarm_relay}), 32'h7);
      check(32'(dac_code), 32'(`DAC_STEP));
      ctl.rd(`REG_STATUS, d, r);
      check(32'({d[11:8], d[7:6], d[0]}), 32'({4'h1, CLS_STEADY, 1'b1}));
      ctl.rd(`REG_PROTO_WORD, d, r);
      check(32'({d[15], d[11:8]}), 32'h11);
      ctl.wr(`REG_CTRL, 32'h12, r);
      ctl.rd(`REG_PROTO_WORD, d, r);
      check(32'({alarm_relay, d[3:0]}), 32'h1);
      watch(64);
      check(32'(lt + dc), 32'h0);
      ctl.rd(`REG_LOG_CNT, d, r);
      check(32'(d[8:0]), 32'(c0[8:0] + 9'h1));
      ctl.wr(`REG_ERRIN, 32'h0, r);
      ctl.wr(`REG_CTRL, 32'h8, r);
      idle(3);
      check(32'(alarm_flag), 32'h1);
      ctl.wr(`REG_CTRL, 32'h0, r);
      idle(3);
      check(32'({alarm_flag, dac_code}), 32'h0);
      foreach (blink[i]) begin
         raise(blink[i]);
         idle(34);
         watch(64);
         check(32'({alarm_relay, lt[7:0]}), 32'(tog[i]));
         check(32'(fc), 32'd32);
         ctl.wr(`REG_CTRL, 32'h4, r);
         idle(2);
         watch(64);
         check(32'({alarm_relay, dc[7:0]}), 32'h100);
         ctl.wr(`REG_CTRL, 32'h0, r);
         drop();
      end
      foreach (fast[i]) classify(fast[i], CLS_FAST);
      foreach (slow[i]) classify(slow[i], CLS_SLOW);
      foreach (hard[i]) classify(hard[i], CLS_STEADY);
      ctl.wr(`REG_CAL_WR, 32'h0012_3456, r);
      ctl.rd(`REG_CAL_RD, d, r);
      check(d, 32'h0012_3456);
      web_rd <= 1'b1;
      idle(3);
      check(web_cal_data, 32'h0012_3456);
      ctl.rd(`REG_LOG_CNT, d, r);
      check(32'(d[9]), 32'h1);
      raise(5);
      ctl.wr(`REG_LOG_IDX, 32'd38, r);
      ctl.rd(`REG_LOG_STAMP, d, r);
      check(d, 32'h0012_3456);
      ctl.rd(`REG_LOG_DATA, d, r);
      check(d, 32'h0000_0805);
      ctl.wr(`REG_LOG_IDX, 32'd0, r);
      ctl.rd(`REG_LOG_DATA, d, r);
      check(d, 32'h0000_0001);
      // alternating codes so every write logs a new event
      for (int k = 0; k < 370; k++) begin
         ctl.wr(`REG_ERRIN, k[0] ? 32'h2 : 32'h3, r);
      end
      ctl.rd(`REG_LOG_CNT, d, r);
      check(32'(d[8:0]), 32'd400);
      ctl.rd(`REG_LOG_DATA, d, r);
      check(d, 32'h0000_0802);
      close_out();
   end
endmodule
